/* rtl/lfsr_octet.v */
// fibonacci shift register that yields eight output bits per step
// assumes the caller raises step once per octet consumed
`include "rx_cond_defines.vh"

module lfsr_octet #(
  parameter LEN = 15,
  parameter TAP = 14
) (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // advance by one octet
  input wire step,
  // octet of the current position, first bit in the msb
  output reg [7:0] octet
);

reg [LEN-1:0] state;
reg [LEN-1:0] walk;
reg fb;
integer i;

always @* begin
  walk = state;
  fb = 1'b0;
  octet = 8'h00;
  for (i = 7; i >= 0; i = i - 1) begin
    fb = walk[LEN-1] ^ walk[TAP-1];
    walk = {walk[LEN-2:0], fb};
    octet[i] = fb;
  end
end

// all-ones seed keeps the register out of the locked zero state
always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    state <= {LEN{1'b1}};
  end else if (step) begin
    state <= walk;
  end
end

endmodule

/* rtl/rx_cond_defines.vh */
// constants for the receive timeslot conditioning stage
// assumes one 40 MHz clock and an octet-wide receive stream tagged with its timeslot
//
// Contract
// (RULE1) each received timeslot 0..31 gets its own conditioning before the PCM output
// (RULE2) a four-bit selector per timeslot picks the internally generated code
// (RULE3) selector 0x0 or 0xE passes the received octet unchanged
// (RULE4) selector 0x1 outputs the octet XOR 0xFF
// (RULE5) selector 0x2 outputs the octet XOR 0xAA
// (RULE6) selector 0x3 outputs the octet XOR 0x55
// (RULE7) selector 0x4 outputs that timeslot's programmable user code
// (RULE8) selector 0x5 outputs busy code 0x7F
// (RULE9) selector 0x6 outputs vacant code 0xFF
// (RULE10) selector 0x7 outputs 111 followed by the five-bit timeslot number
// (RULE11) selector 0x8 outputs mux out-of-frame code 0x1A
// (RULE12) selector 0x9 gives A-law milliwatt, 0xA gives mu-law milliwatt
// (RULE13) selector 0xB inverts only the most significant bit
// (RULE14) selector 0xC inverts all bits except the most significant
// (RULE15) selector 0xD gives PRBS x15+x14+1 or quasi-random signal, by type bit
// (RULE16) selector 0xF marks a D/E slot sourced per the link source select field
// (RULE17) each user code is eight-bit read-write, resets to all ones
// (RULE18) the selector is read afresh at every occurrence of a timeslot
// (RULE19) patterns advance one octet per conditioned timeslot, continuous over frames
`ifndef RX_COND_DEFINES_VH
`define RX_COND_DEFINES_VH

// register map
`define ADDR_W 16
`define CHAN_CTRL_BASE 16'h0360
`define USER_CODE_BASE 16'h0380
`define NUM_SLOTS 32
`define PTYPE_ADDR 16'h0123
`define SIGDL_ADDR 16'h010C
`define STATUS_ADDR 16'h0FF0
`define BLK_HI 15
`define BLK_LO 5
`define PTYPE_BIT 7
`define SIGDL_W 3

// channel control fields
`define COND_HI 3
`define COND_LO 0
`define LAPD_HI 7
`define LAPD_LO 6
`define CHAN_CTRL_RST 8'h00
`define USER_CODE_RST 8'hFF
`define SIGDL_RST 3'h0

// conditioning selector codes
`define COND_PASS 4'h0
`define COND_INV 4'h1
`define COND_EVEN 4'h2
`define COND_ODD 4'h3
`define COND_USER 4'h4
`define COND_BUSY 4'h5
`define COND_VACANT 4'h6
`define COND_TSNUM 4'h7
`define COND_OOF 4'h8
`define COND_MW_A 4'h9
`define COND_MW_U 4'hA
`define COND_MSB 4'hB
`define COND_LOW7 4'hC
`define COND_PRBS 4'hD
`define COND_PASS2 4'hE
`define COND_DE 4'hF

// masks and fixed codes
`define MASK_ALL 8'hFF
`define MASK_EVEN 8'hAA
`define MASK_ODD 8'h55
`define MASK_MSB 8'h80
`define MASK_LOW7 8'h7F
`define CODE_BUSY 8'h7F
`define CODE_VACANT 8'hFF
`define CODE_OOF 8'h1A
`define TSNUM_HEAD 3'h7

// milliwatt tables, entry 0 in the low byte
`define MW_A_TABLE 64'hB4A1_A1B4_3421_2134
`define MW_U_TABLE 64'h9E8B_8B9E_1E0B_0B1E
`define MW_IDX_W 3

// pattern generators
`define PRBS_LEN 15
`define PRBS_TAP 14
`define QRT_LEN 20
`define QRT_TAP 17
`define QRT_RUN 4'hE
`define RUN_ONE 4'h1
`define RUN_ZERO 4'h0

`endif

/* rtl/rx_timeslot_conditioning.v */
// receive timeslot conditioning between the line data and the backplane pcm output
// assumes octets arrive with their timeslot number, one per valid cycle,
// and a register master that never issues read and write together
`include "rx_cond_defines.vh"

module rx_timeslot_conditioning (
  // clock and reset
  input wire clk,
  input wire reset_n,

  // register port
  input wire [15:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,

  // received line octets
  input wire [7:0] rx_octet,
  input wire [4:0] rx_timeslot,
  input wire rx_valid,

  // backplane pcm side
  output reg [7:0] pcm_octet,
  output reg [4:0] pcm_timeslot,
  output reg pcm_valid,
  output reg de_slot,
  output reg [2:0] rx_sig_link_source_select
);

// per-timeslot registers, pattern type bit and status capture
reg [7:0] rx_channel_control [0:31];
reg [7:0] rx_user_code [0:31];
reg pattern_type_select;
reg [4:0] last_timeslot;
reg last_de;

// pattern state
reg [2:0] mw_index;
reg [3:0] zero_run;
reg [3:0] next_zero_run;
reg [7:0] quasi_random_test_signal;

// decode of the current octet
wire [3:0] rx_conditioning_select;
wire [7:0] user_code;
wire [7:0] prbs_octet;
wire [7:0] qrt_raw;
wire [63:0] mw_a_shift;
wire [63:0] mw_u_shift;
wire [7:0] mw_a_octet;
wire [7:0] mw_u_octet;
wire is_mw;
wire is_pattern;
wire prbs_step;
wire qrt_step;
reg [7:0] next_pcm_octet;
reg next_de_slot;

// register port decode
wire hit_chan_ctrl;
wire hit_user_code;
wire hit_ptype;
wire hit_sigdl;
wire hit_status;
wire [4:0] reg_index;
reg [7:0] next_reg_rdata;

// qualified write strobes
wire wr_chan_ctrl;
wire wr_user_code;
wire wr_ptype;
wire wr_sigdl;

integer i;

// byte address, the timeslot sits in the low five bits
assign reg_index = reg_addr[`BLK_LO-1:0];
assign hit_chan_ctrl = (reg_addr[`BLK_HI:`BLK_LO] == `CHAN_CTRL_BASE >> `BLK_LO);
assign hit_user_code = (reg_addr[`BLK_HI:`BLK_LO] == `USER_CODE_BASE >> `BLK_LO);
assign hit_ptype = (reg_addr == `PTYPE_ADDR);
assign hit_sigdl = (reg_addr == `SIGDL_ADDR);
assign hit_status = (reg_addr == `STATUS_ADDR);

assign wr_chan_ctrl = reg_wr && hit_chan_ctrl;
assign wr_user_code = reg_wr && hit_user_code;
assign wr_ptype = reg_wr && hit_ptype;
assign wr_sigdl = reg_wr && hit_sigdl;

// (RULE18) selector fetched per occurrence
// a write landing with the octet applies from the next occurrence
assign rx_conditioning_select =
  rx_channel_control[rx_timeslot][`COND_HI:`COND_LO];
assign user_code = rx_user_code[rx_timeslot];

// (RULE12) milliwatt table lookup
assign mw_a_shift = `MW_A_TABLE >> {mw_index, 3'b000};
assign mw_u_shift = `MW_U_TABLE >> {mw_index, 3'b000};
assign mw_a_octet = mw_a_shift[7:0];
assign mw_u_octet = mw_u_shift[7:0];

assign is_mw = (rx_conditioning_select == `COND_MW_A) ||
  (rx_conditioning_select == `COND_MW_U);
assign is_pattern = (rx_conditioning_select == `COND_PRBS);

// (RULE19) step only on conditioned octets
assign prbs_step = rx_valid && is_pattern && !pattern_type_select;
assign qrt_step = rx_valid && is_pattern && pattern_type_select;

// (RULE15) x15+x14+1 generator
lfsr_octet #(
  .LEN(`PRBS_LEN),
  .TAP(`PRBS_TAP)
) prbs_gen (
  .clk(clk),
  .reset_n(reset_n),
  .step(prbs_step),
  .octet(prbs_octet)
);

// (RULE15) x20+x17+1 source for the quasi-random signal
lfsr_octet #(
  .LEN(`QRT_LEN),
  .TAP(`QRT_TAP)
) qrt_gen (
  .clk(clk),
  .reset_n(reset_n),
  .step(qrt_step),
  .octet(qrt_raw)
);

// quasi-random signal: a one is forced after a run of fourteen zeros
always @* begin
  next_zero_run = zero_run;
  quasi_random_test_signal = 8'h00;
  for (i = 7; i >= 0; i = i - 1) begin
    if (next_zero_run == `QRT_RUN) begin
      quasi_random_test_signal[i] = 1'b1;
      next_zero_run = `RUN_ZERO;
    end else if (qrt_raw[i]) begin
      quasi_random_test_signal[i] = 1'b1;
      next_zero_run = `RUN_ZERO;
    end else begin
      quasi_random_test_signal[i] = 1'b0;
      next_zero_run = next_zero_run + `RUN_ONE;
    end
  end
end

// (RULE1) per-timeslot output selection
always @* begin
  next_pcm_octet = rx_octet;
  next_de_slot = 1'b0;
  case (rx_conditioning_select)
    // (RULE3) unchanged octet
    `COND_PASS: begin
      next_pcm_octet = rx_octet;
    end
    `COND_PASS2: begin
      next_pcm_octet = rx_octet;
    end
    // (RULE4) full complement
    `COND_INV: begin
      next_pcm_octet = rx_octet ^ `MASK_ALL;
    end
    // (RULE5) even bits inverted
    `COND_EVEN: begin
      next_pcm_octet = rx_octet ^ `MASK_EVEN;
    end
    // (RULE6) odd bits inverted
    `COND_ODD: begin
      next_pcm_octet = rx_octet ^ `MASK_ODD;
    end
    // (RULE7) programmable user code
    `COND_USER: begin
      next_pcm_octet = user_code;
    end
    // (RULE8) busy code
    `COND_BUSY: begin
      next_pcm_octet = `CODE_BUSY;
    end
    // (RULE9) vacant code
    `COND_VACANT: begin
      next_pcm_octet = `CODE_VACANT;
    end
    // (RULE10) busy code with slot number
    `COND_TSNUM: begin
      next_pcm_octet = {`TSNUM_HEAD, rx_timeslot};
    end
    // (RULE11) out-of-frame code
    `COND_OOF: begin
      next_pcm_octet = `CODE_OOF;
    end
    // (RULE12) a-law milliwatt
    `COND_MW_A: begin
      next_pcm_octet = mw_a_octet;
    end
    // (RULE12) mu-law milliwatt
    `COND_MW_U: begin
      next_pcm_octet = mw_u_octet;
    end
    // (RULE13) msb only inverted
    `COND_MSB: begin
      next_pcm_octet = rx_octet ^ `MASK_MSB;
    end
    // (RULE14) all but msb inverted
    `COND_LOW7: begin
      next_pcm_octet = rx_octet ^ `MASK_LOW7;
    end
    // (RULE15) pattern chosen by type bit
    `COND_PRBS: begin
      if (pattern_type_select) begin
        next_pcm_octet = quasi_random_test_signal;
      end else begin
        next_pcm_octet = prbs_octet;
      end
    end
    // (RULE16) d/e slot flagged downstream
    `COND_DE: begin
      next_pcm_octet = rx_octet;
      next_de_slot = 1'b1;
    end
    default: begin
      next_pcm_octet = rx_octet;
      next_de_slot = 1'b0;
    end
  endcase
end

// (RULE2) registered conditioned output
always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    pcm_octet <= 8'h00;
    pcm_timeslot <= 5'h00;
    pcm_valid <= 1'b0;
    de_slot <= 1'b0;
  end else begin
    pcm_valid <= rx_valid;
    if (rx_valid) begin
      pcm_octet <= next_pcm_octet;
      pcm_timeslot <= rx_timeslot;
      de_slot <= next_de_slot;
    end
  end
end

// (RULE19) milliwatt position carries over frames
always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    mw_index <= 3'h0;
  end else if (rx_valid && is_mw) begin
    mw_index <= mw_index + 3'h1;
  end
end

// (RULE19) zero run length carries over frames
always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    zero_run <= `RUN_ZERO;
  end else if (qrt_step) begin
    zero_run <= next_zero_run;
  end
end

// last octet seen, for the status register
always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    last_timeslot <= 5'h00;
    last_de <= 1'b0;
  end else if (rx_valid) begin
    last_timeslot <= rx_timeslot;
    last_de <= next_de_slot;
  end
end

// channel control storage, reserved bits 5:4 not kept
always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    for (i = 0; i < `NUM_SLOTS; i = i + 1) begin
      rx_channel_control[i] <= `CHAN_CTRL_RST;
    end
  end else if (wr_chan_ctrl) begin
    rx_channel_control[reg_index] <=
      {reg_wdata[`LAPD_HI:`LAPD_LO], 2'b00, reg_wdata[`COND_HI:`COND_LO]};
  end
end

// (RULE17) user codes reset to all ones
always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    for (i = 0; i < `NUM_SLOTS; i = i + 1) begin
      rx_user_code[i] <= `USER_CODE_RST;
    end
  end else if (wr_user_code) begin
    rx_user_code[reg_index] <= reg_wdata;
  end
end

// pattern type and link source select
always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    pattern_type_select <= 1'b0;
    rx_sig_link_source_select <= `SIGDL_RST;
  end else begin
    if (wr_ptype) begin
      pattern_type_select <= reg_wdata[`PTYPE_BIT];
    end
    // (RULE16) d/e source select field
    if (wr_sigdl) begin
      rx_sig_link_source_select <= reg_wdata[`SIGDL_W-1:0];
    end
  end
end

// read mux, unmapped addresses read as zero
always @* begin
  next_reg_rdata = 8'h00;
  if (hit_chan_ctrl) begin
    next_reg_rdata = rx_channel_control[reg_index];
  end else if (hit_user_code) begin
    next_reg_rdata = rx_user_code[reg_index];
  end else if (hit_ptype) begin
    next_reg_rdata = {pattern_type_select, 7'h00};
  end else if (hit_sigdl) begin
    next_reg_rdata = {5'h00, rx_sig_link_source_select};
  end else if (hit_status) begin
    next_reg_rdata = {last_de, 2'b00, last_timeslot};
  end
end

// read data one cycle after the strobe, zero otherwise
always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    reg_rdata <= 8'h00;
  end else if (reg_rd) begin
    reg_rdata <= next_reg_rdata;
  end else begin
    reg_rdata <= 8'h00;
  end
end

endmodule

/* verification/pcm_sink.sv */
// backplane pcm receive side: latches each conditioned octet
// assumes pcm_valid pulses once per octet
module pcm_sink (
  // clock
  input wire logic clk,
  // conditioned stream
  input wire logic [7:0] pcm_octet,
  input wire logic [4:0] pcm_timeslot,
  input wire logic pcm_valid,
  input wire logic de_slot,
  // latched copy
  output logic [7:0] got_octet,
  output logic [4:0] got_ts,
  output logic got_de
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge clk) begin
    if (pcm_valid) begin
      got_octet <= pcm_octet;
      got_ts <= pcm_timeslot;
      got_de <= de_slot;
    end
  end
endmodule

/* verification/rx_cond_props.sv */
// assertions on the ports of the receive conditioning stage
// assumes a bind to the top module; selectors and user codes are shadowed from writes
module rx_cond_props (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // streams
  input wire logic [7:0] rx_octet,
  input wire logic [4:0] rx_timeslot,
  input wire logic rx_valid,
  input wire logic [7:0] pcm_octet,
  input wire logic [4:0] pcm_timeslot,
  input wire logic pcm_valid,
  input wire logic de_slot
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] sel [32];
  logic [7:0] ucode [32];
  logic [3:0] s;
  logic [7:0] want;
  logic is_de;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  assign s = sel[rx_timeslot];
  assign is_de = (s == 4'hF);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 32; i++) begin
        sel[i] <= 4'h0;
        ucode[i] <= 8'hFF;
      end
    end else if (reg_wr && reg_addr[15:5] == 11'h01B) begin
      sel[reg_addr[4:0]] <= reg_wdata[3:0];
    end else if (reg_wr && reg_addr[15:5] == 11'h01C) begin
      ucode[reg_addr[4:0]] <= reg_wdata;
    end
  end
  always_comb begin
    case (s)
      4'h1: want = rx_octet ^ 8'hFF;
      4'h2: want = rx_octet ^ 8'hAA;
      4'h3: want = rx_octet ^ 8'h55;
      4'h4: want = ucode[rx_timeslot];
      4'h5: want = 8'h7F;
      4'h6: want = 8'hFF;
      4'h7: want = {3'b111, rx_timeslot};
      4'h8: want = 8'h1A;
      4'hB: want = rx_octet ^ 8'h80;
      4'hC: want = rx_octet ^ 8'h7F;
      default: want = rx_octet;
    endcase
  end
  ts_follow_a: assert property (rx_valid |=> pcm_valid && pcm_timeslot == $past(rx_timeslot))
    else $error("timeslot not carried to output");
  quiet_out_a: assert property (!rx_valid |=> !pcm_valid)
    else $error("output valid without input");
  pass_code_a: assert property (rx_valid && (s == 4'h0 || s == 4'hE) |=> pcm_octet == $past(rx_octet))
    else $error("pass-through octet altered");
  xor_mask_a: assert property (rx_valid && (s inside {4'h1, 4'h2, 4'h3, 4'hB, 4'hC}) |=> pcm_octet == $past(want))
    else $error("masked octet wrong");
  user_code_a: assert property (rx_valid && s == 4'h4 |=> pcm_octet == $past(want))
    else $error("user code not substituted");
  fixed_code_a: assert property (rx_valid && (s inside {4'h5, 4'h6, 4'h8}) |=> pcm_octet == $past(want))
    else $error("fixed code wrong");
  ts_number_a: assert property (rx_valid && s == 4'h7 |=> pcm_octet == $past(want))
    else $error("timeslot number code wrong");
  de_flag_a: assert property (rx_valid |=> de_slot == $past(is_de) && (!de_slot || pcm_octet == $past(rx_octet)))
    else $error("data link slot flag wrong");
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
endmodule

/* verification/tb_rx_timeslot_conditioning.sv */
// testbench for the receive conditioning stage
// assumes the design files and the checker are compiled first
module tb_rx_timeslot_conditioning;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] rx_octet = 8'h00;
  logic [4:0] rx_timeslot = 5'h00;
  logic rx_valid = 1'b0;
  wire [7:0] reg_rdata, pcm_octet, got_octet;
  wire [4:0] pcm_timeslot, got_ts;
  wire pcm_valid, de_slot, got_de;
  wire [2:0] link_sel;
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;
  always #12.5 clk = ~clk;
  rx_timeslot_conditioning dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_octet(rx_octet), .rx_timeslot(rx_timeslot),
    .rx_valid(rx_valid), .pcm_octet(pcm_octet), .pcm_timeslot(pcm_timeslot), .pcm_valid(pcm_valid),
    .de_slot(de_slot), .rx_sig_link_source_select(link_sel));
  pcm_sink sink (.clk(clk), .pcm_octet(pcm_octet), .pcm_timeslot(pcm_timeslot), .pcm_valid(pcm_valid),
    .de_slot(de_slot), .got_octet(got_octet), .got_ts(got_ts), .got_de(got_de));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic send(input logic [4:0] t, input logic [7:0] d);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_timeslot <= t;
    rx_octet <= d;
    @(posedge clk);
    rx_valid <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  function automatic logic [7:0] expv(input logic [3:0] s, input logic [7:0] d, input logic [4:0] t);
    case (s)
      4'h1: expv = d ^ 8'hFF;
      4'h2: expv = d ^ 8'hAA;
      4'h3: expv = d ^ 8'h55;
      4'h4: expv = 8'h3C;
      4'h5: expv = 8'h7F;
      4'h6: expv = 8'hFF;
      4'h7: expv = {3'b111, t};
      4'h8: expv = 8'h1A;
      4'hB: expv = d ^ 8'h80;
      4'hC: expv = d ^ 8'h7F;
      default: expv = d;
    endcase
  endfunction
  task automatic t_regs();
    logic [7:0] v;
    rd(16'h0380, v);
    check(v, 8'hFF);
    rd(16'h0360, v);
    check(v, 8'h00);
    rd(16'h0200, v);
    check(v, 8'h00);
    wr(16'h0394, 8'h3C);
    rd(16'h0394, v);
    check(v, 8'h3C);
    rd(16'h0395, v);
    check(v, 8'hFF);
  endtask
  task automatic t_mw();
    logic [63:0] a_tab = 64'hB4A1_A1B4_3421_2134;
    logic [63:0] u_tab = 64'h9E8B_8B9E_1E0B_0B1E;
    wr(16'h0369, 8'h09);
    wr(16'h036A, 8'h0A);
    for (int i = 0; i < 8; i++) begin
      send(5'd9, 8'h00);
      check(got_octet, a_tab[8*i+:8]);
    end
    for (int i = 0; i < 8; i++) begin
      send(5'd10, 8'h00);
      check(got_octet, u_tab[8*i+:8]);
    end
  endtask
  task automatic t_codes();
    logic [3:0] s;
    for (int i = 0; i < 16; i++) begin
      s = i[3:0];
      wr(16'h0370 + 16'(i), {4'h0, s});
      send(5'd16 + 5'(i), 8'h12 + 8'(i));
      check({3'b000, got_ts}, 8'd16 + 8'(i));
      check({7'h00, got_de}, {7'h00, s == 4'hF});
      if (s == 4'h9) begin
        check(got_octet, 8'h34);
      end else if (s == 4'hA) begin
        check(got_octet, 8'h0B);
      end else if (s == 4'hD) begin
        check(got_octet, 8'h00);
      end else begin
        check(got_octet, expv(s, 8'h12 + 8'(i), 5'd16 + 5'(i)));
      end
    end
    wr(16'h0371, 8'h05);
    send(5'd17, 8'h12);
    check(got_octet, 8'h7F);
  endtask
  task automatic t_link();
    logic [7:0] v;
    wr(16'h010C, 8'h05);
    repeat (2) @(posedge clk);
    #1 check({5'h00, link_sel}, 8'h05);
    rd(16'h0FF0, v);
    check(v, 8'h11);
    wr(16'h0123, 8'h80);
    rd(16'h0123, v);
    check(v, 8'h80);
    send(5'd29, 8'h55);
    check(got_octet, 8'h00);
    send(5'd29, 8'h55);
    check(got_octet, 8'h02);
  endtask
  task automatic report_and_stop();
    if (fail_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      report_and_stop();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    t_regs();
    t_mw();
    t_codes();
    t_link();
    report_and_stop();
  end
endmodule
bind rx_timeslot_conditioning rx_cond_props chk (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_octet(rx_octet),
  .rx_timeslot(rx_timeslot), .rx_valid(rx_valid), .pcm_octet(pcm_octet), .pcm_timeslot(pcm_timeslot),
  .pcm_valid(pcm_valid), .de_slot(de_slot));
